// ### rsvc_far_model.sv
`timescale 1ns/1ps
module rsvc_far_model #(
	parameter int MX_DLY = 8,
	parameter int CI_DLY = 2,
	parameter int PS_DLY = 5
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic modexp_go,
	input  wire logic cipher_go,
	input  wire logic pause_req,
	output logic      modexp_done,
	output logic      cipher_done,
	output logic      pause_sent
);
	int mx_cnt;
	int ci_cnt;
	int ps_cnt;
	// ----------------------------------------
	// Engines answer after a fixed latency
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) mx_cnt <= 0;
		else if (modexp_go) mx_cnt <= MX_DLY;
		else if (mx_cnt > 0) mx_cnt <= mx_cnt - 1;
	end
	always_ff @(posedge mclk) begin
		if (rst) ci_cnt <= 0;
		else if (cipher_go) ci_cnt <= CI_DLY;
		else if (ci_cnt > 0) ci_cnt <= ci_cnt - 1;
	end
	always_ff @(posedge mclk) begin
		if (rst) ps_cnt <= 0;
		else if (pause_req) ps_cnt <= PS_DLY;
		else if (ps_cnt > 0) ps_cnt <= ps_cnt - 1;
	end
	assign modexp_done = (mx_cnt == 1);
	assign cipher_done = (ci_cnt == 1);
	assign pause_sent  = (ps_cnt == 1);
endmodule : rsvc_far_model

// ### rsvc_pkg.sv
`timescale 1ns/1ps
package rsvc_pkg;
	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTL_MODEXP   = 15;
	localparam int CTL_DIG_EN   = 14;
	localparam int CTL_DIG_IV   = 13;
	localparam int CTL_DIG_LAST = 12;
	localparam int CTL_CIPHER   = 11;
	localparam int CTL_COP_HI   = 10;
	localparam int CTL_COP_LO   = 9;
	localparam int CTL_PENDING_COUNT_DECREMENT   = 8;
	localparam int CTL_FC_HI    = 7;
	localparam int CTL_FC_LO    = 6;
	localparam int CTL_RECEIVE_ENABLE     = 0;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam int STA_FC_IDLE  = 14;
	// ----------------------------------------
	// Status vector fields
	// ----------------------------------------
	localparam int SV_PREV_DROP = 16;
	localparam int SV_CARRIER   = 18;
	localparam int SV_CRC_ERR   = 20;
	localparam int SV_LEN_ERR   = 21;
	localparam int SV_TYPE      = 22;
	localparam int SV_OK        = 23;
	localparam int SV_MCAST     = 24;
	localparam int SV_BCAST     = 25;
	localparam int SV_DRIBBLE   = 26;
	localparam int SV_CTRL      = 27;
	localparam int SV_PAUSE     = 28;
	localparam int SV_UNK_OP    = 29;
	localparam int SV_VLAN      = 30;
	localparam int SV_FILT_LO   = 31;
	localparam int SV_BYTES     = 6;
	localparam int HDR_BYTES    = 8;
	// ----------------------------------------
	// Frame constants
	// ----------------------------------------
	localparam logic [15:0] MAX_LEN     = 16'd1500;
	localparam logic [15:0] ET_CTRL     = 16'h8808;
	localparam logic [15:0] ET_VLAN     = 16'h8100;
	localparam logic [15:0] OP_PAUSE    = 16'h0001;
	localparam logic [47:0] DA_PAUSE    = 48'h0180c2000001;
	localparam logic [15:0] OVERHEAD    = 16'd18;
	localparam logic [15:0] MIN_FRAME   = 16'd64;
	localparam logic [15:0] MIN_PAYLOAD = 16'd46;
	localparam logic [15:0] BUF_END     = 16'h5fff;
	localparam logic [15:0] ZERO_TIMER  = 16'h0000;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ        = 125;
	localparam int PAUSE_PERIOD_US = 200;
	localparam int PAUSE_PERIOD_CYC = PAUSE_PERIOD_US * CLK_MHZ;
	typedef enum logic [2:0] {
		RSVC_FC_IDLE   = 3'b000,
		RSVC_FC_SINGLE = 3'b001,
		RSVC_FC_END    = 3'b010,
		RSVC_FC_PERIOD = 3'b011,
		RSVC_FC_BP     = 3'b100
	} rsvc_fc_t;
	typedef enum logic [1:0] {
		RSVC_RX_IDLE = 2'b00,
		RSVC_RX_DATA = 2'b01,
		RSVC_RX_HDR  = 2'b10
	} rsvc_rx_t;
endpackage : rsvc_pkg

module rsvc_parse import rsvc_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        sof,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	input  wire logic [15:0] byte_index,
	output logic      [15:0] len_type,
	output logic             bcast,
	output logic             mcast,
	output logic             ctrl_frame,
	output logic             pause_op,
	output logic             unknown_op,
	output logic             vlan
);
	logic [47:0] da_reg;
	logic [15:0] op_reg;
	always_ff @(posedge mclk) begin
		if (rst || sof) begin
			da_reg   <= 48'h000000000000;
			len_type <= 16'h0000;
			op_reg   <= 16'h0000;
		end else if (byte_valid) begin
			if (byte_index < 16'd6)
				da_reg <= {da_reg[39:0], byte_data};
			else if (byte_index == 16'd12)
				len_type[15:8] <= byte_data;
			else if (byte_index == 16'd13)
				len_type[7:0] <= byte_data;
			else if (byte_index == 16'd14)
				op_reg[15:8] <= byte_data;
			else if (byte_index == 16'd15)
				op_reg[7:0] <= byte_data;
		end
	end
	always_comb begin
		bcast      = &da_reg;
		mcast      = da_reg[40] && !bcast;
		ctrl_frame = (len_type == ET_CTRL);
		pause_op   = ctrl_frame && (op_reg == OP_PAUSE) && (da_reg == DA_PAUSE);
		unknown_op = ctrl_frame && (op_reg != OP_PAUSE);
		vlan       = (len_type == ET_VLAN);
	end
endmodule : rsvc_parse

// ### rsvc_top.sv
`timescale 1ns/1ps
// How it works
// - Status vector bits 15:0 hold frame byte count, low byte first.
// - Bit 23 set only with good checksum and no symbol errors.
// - Bit 22 set when type/length field exceeds 1500.
// - Bit 21 set when valid length disagrees with received payload size.
// - Bit 20 set when received checksum mismatches computed one.
// - Bit 18 set if carrier activity seen since previous frame.
// - Bit 16 set if long or dropped frame since previous frame.
// - Bit 25 broadcast, bit 24 multicast destination.
// - Bit 26 set on 1 to 7 dribble bits, which are discarded.
// - Bit 27 set for MAC control frame type.
// - Bit 28 valid pause with valid destination, bit 29 unknown opcode.
// - Bit 30 set for VLAN tagged frame.
// - Bits 31 to 36 report filter matches sampled for this frame.
// - Control bit 15 starts modular exponentiation, cleared on completion.
// - Control bit 14 enables feeding DMA data into the digest.
// - Control bit 13 loads digest initial value from hash memory.
// - Control bit 12 marks next digest transfer as final, padded.
// - Control bit 11 starts cipher, cleared on completion.
// - Bits 10-9 select cipher operation; 11 is reserved.
// - Writing one to bit 8 decrements pending count; bit self-clears.
// - Full duplex flow control: single, periodic, end with zero timer.
// - Half duplex nonzero setting sends continuous preamble backpressure.
// - Each stored frame preceded by next pointer and six-byte vector.
// - Pending count increments per stored frame; overflow discards frame.
// - Control bit 0 gates storing of filtered frames.
module rsvc_top import rsvc_pkg::*; #(
	parameter int PERIOD_CYC = PAUSE_PERIOD_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ctl_wr,
	input  wire logic [1:0]  ctl_be,
	input  wire logic [15:0] ctl_wdata,
	output logic      [15:0] ctl_rdata,
	output logic      [15:0] status_rdata,
	input  wire logic        rx_sof,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_eof,
	input  wire logic        rx_crc_ok,
	input  wire logic        rx_symbol_err,
	input  wire logic [2:0]  rx_dribble_bits,
	input  wire logic        rx_filter_pass,
	input  wire logic [5:0]  rx_filter_match,
	input  wire logic        rx_carrier_event,
	input  wire logic        rx_drop_event,
	input  wire logic [15:0] rx_buf_start,
	input  wire logic [15:0] rx_head_addr,
	output logic             mem_wr_en,
	output logic      [15:0] mem_wr_addr,
	output logic      [7:0]  mem_wr_data,
	output logic             rx_commit,
	output logic      [15:0] rx_next_head,
	output logic      [7:0]  pending_packet_count,
	input  wire logic        modexp_done,
	output logic             modexp_go,
	input  wire logic        cipher_done,
	output logic             cipher_go,
	output logic      [1:0]  cipher_op_select,
	output logic             cipher_op_reserved,
	output logic             digest_enable,
	output logic             digest_load_iv,
	output logic             digest_last_block,
	output logic      [4:0]  aux_ctrl,
	input  wire logic        full_duplex_select,
	input  wire logic [15:0] pause_timer_value,
	output logic             pause_req,
	output logic      [15:0] pause_timer_out,
	input  wire logic        pause_sent,
	output logic             backpressure,
	output logic             flow_ctrl_idle
);
	// ----------------------------------------
	// Control register
	// ----------------------------------------
	logic [15:0] ctl_reg;
	logic        wr_lo;
	logic        wr_hi;
	logic        dec_req;
	logic        fc_clear;
	assign wr_lo   = ctl_wr && ctl_be[0];
	assign wr_hi   = ctl_wr && ctl_be[1];
	assign dec_req = wr_hi && ctl_wdata[CTL_PENDING_COUNT_DECREMENT];

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl_reg <= CTL_RESET;
		end else begin
			if (wr_hi) begin
				ctl_reg[CTL_DIG_EN:CTL_DIG_LAST] <= ctl_wdata[CTL_DIG_EN:CTL_DIG_LAST];
				ctl_reg[CTL_COP_HI:CTL_COP_LO]   <= ctl_wdata[CTL_COP_HI:CTL_COP_LO];
			end
			if (wr_hi && ctl_wdata[CTL_MODEXP])
				ctl_reg[CTL_MODEXP] <= 1'b1;
			else if (modexp_done)
				ctl_reg[CTL_MODEXP] <= 1'b0;
			if (wr_hi && ctl_wdata[CTL_CIPHER])
				ctl_reg[CTL_CIPHER] <= 1'b1;
			else if (cipher_done)
				ctl_reg[CTL_CIPHER] <= 1'b0;
			ctl_reg[CTL_PENDING_COUNT_DECREMENT] <= 1'b0;
			if (wr_lo)
				ctl_reg[7:0] <= ctl_wdata[7:0];
			else if (fc_clear)
				ctl_reg[CTL_FC_HI:CTL_FC_LO] <= 2'b00;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			modexp_go <= 1'b0;
			cipher_go <= 1'b0;
		end else begin
			modexp_go <= wr_hi && ctl_wdata[CTL_MODEXP] && !ctl_reg[CTL_MODEXP];
			cipher_go <= wr_hi && ctl_wdata[CTL_CIPHER] && !ctl_reg[CTL_CIPHER];
		end
	end

	assign digest_enable      = ctl_reg[CTL_DIG_EN];
	assign digest_load_iv     = ctl_reg[CTL_DIG_IV];
	assign digest_last_block  = ctl_reg[CTL_DIG_LAST];
	assign cipher_op_select   = ctl_reg[CTL_COP_HI:CTL_COP_LO];
	assign cipher_op_reserved = &ctl_reg[CTL_COP_HI:CTL_COP_LO];
	assign aux_ctrl           = ctl_reg[5:1];
	assign ctl_rdata          = ctl_reg;

	// ----------------------------------------
	// Flow control
	// ----------------------------------------
	rsvc_fc_t    fc_state;
	logic [31:0] fc_timer;
	logic [1:0]  fc_op;
	assign fc_op = ctl_reg[CTL_FC_HI:CTL_FC_LO];

	// Host must only alter the mode while idle reads one
	always_ff @(posedge mclk) begin
		if (rst) begin
			fc_state  <= RSVC_FC_IDLE;
			fc_timer  <= 32'd0;
			pause_req <= 1'b0;
		end else begin
			pause_req <= 1'b0;
			case (fc_state)
				RSVC_FC_IDLE: begin
					if (!full_duplex_select && fc_op != 2'b00) begin
						fc_state <= RSVC_FC_BP;
					end else if (full_duplex_select) begin
						case (fc_op)
							2'b01: begin
								fc_state  <= RSVC_FC_SINGLE;
								pause_req <= 1'b1;
							end
							2'b10: begin
								fc_state  <= RSVC_FC_PERIOD;
								pause_req <= 1'b1;
								fc_timer  <= 32'(PERIOD_CYC - 1);
							end
							2'b11: begin
								fc_state  <= RSVC_FC_END;
								pause_req <= 1'b1;
							end
							default: fc_state <= RSVC_FC_IDLE;
						endcase
					end
				end
				RSVC_FC_SINGLE, RSVC_FC_END: begin
					if (pause_sent)
						fc_state <= RSVC_FC_IDLE;
				end
				RSVC_FC_PERIOD: begin
					if (fc_op != 2'b10) begin
						fc_state <= RSVC_FC_IDLE;
					end else if (fc_timer == 32'd0) begin
						pause_req <= 1'b1;
						fc_timer  <= 32'(PERIOD_CYC - 1);
					end else begin
						fc_timer <= fc_timer - 32'd1;
					end
				end
				RSVC_FC_BP: begin
					if (fc_op == 2'b00)
						fc_state <= RSVC_FC_IDLE;
				end
				default: fc_state <= RSVC_FC_IDLE;
			endcase
		end
	end

	assign fc_clear        = (fc_state == RSVC_FC_SINGLE || fc_state == RSVC_FC_END) && pause_sent;
	assign pause_timer_out = (fc_state == RSVC_FC_END) ? ZERO_TIMER : pause_timer_value;
	assign backpressure    = (fc_state == RSVC_FC_BP);
	assign flow_ctrl_idle  = (fc_state == RSVC_FC_IDLE) && !pause_req;

	// ----------------------------------------
	// Frame parsing
	// ----------------------------------------
	rsvc_rx_t    rx_state;
	logic [15:0] byte_cnt;
	logic [15:0] len_type;
	logic        p_bcast;
	logic        p_mcast;
	logic        p_ctrl;
	logic        p_pause;
	logic        p_unk;
	logic        p_vlan;

	rsvc_parse u_parse (
		.mclk       (mclk),
		.rst        (rst),
		.sof        (rx_sof),
		.byte_valid (rx_valid && rx_state == RSVC_RX_DATA),
		.byte_data  (rx_data),
		.byte_index (byte_cnt),
		.len_type   (len_type),
		.bcast      (p_bcast),
		.mcast      (p_mcast),
		.ctrl_frame (p_ctrl),
		.pause_op   (p_pause),
		.unknown_op (p_unk),
		.vlan       (p_vlan)
	);

	// ----------------------------------------
	// Events since previous frame
	// ----------------------------------------
	logic carrier_seen;
	logic drop_seen;
	logic hdr_done;
	logic overflow_drop;
	always_ff @(posedge mclk) begin
		if (rst) begin
			carrier_seen <= 1'b0;
			drop_seen    <= 1'b0;
		end else begin
			if (rx_carrier_event)
				carrier_seen <= 1'b1;
			else if (hdr_done)
				carrier_seen <= 1'b0;
			if (rx_drop_event || overflow_drop)
				drop_seen <= 1'b1;
			else if (hdr_done)
				drop_seen <= 1'b0;
		end
	end

	// ----------------------------------------
	// Status vector and storage
	// ----------------------------------------
	logic [47:0] rsv_reg;
	logic [47:0] rsv_next;
	logic [15:0] payload;
	logic        len_bad;
	logic [2:0]  hdr_idx;
	logic [15:0] next_ptr;
	logic [15:0] raw_next;
	logic        receive_enable_frame;

	function automatic logic [15:0] wrap(input logic [15:0] a, input logic [15:0] base);
		wrap = (a > BUF_END) ? 16'(a - BUF_END - 16'd1 + base) : a;
	endfunction : wrap

	assign payload = byte_cnt - OVERHEAD;
	assign len_bad = (len_type <= MAX_LEN) && (payload != len_type) &&
		!(len_type < MIN_PAYLOAD && byte_cnt == MIN_FRAME);
	assign raw_next = 16'(rx_head_addr + 16'(HDR_BYTES) + byte_cnt + {15'd0, byte_cnt[0]});

	always_comb begin
		rsv_next                 = 48'h000000000000;
		rsv_next[15:0]           = byte_cnt;
		rsv_next[SV_PREV_DROP]   = drop_seen || rx_drop_event;
		rsv_next[SV_CARRIER]     = carrier_seen || rx_carrier_event;
		rsv_next[SV_CRC_ERR]     = !rx_crc_ok;
		rsv_next[SV_LEN_ERR]     = len_bad;
		rsv_next[SV_TYPE]        = (len_type > MAX_LEN);
		rsv_next[SV_OK]          = rx_crc_ok && !rx_symbol_err;
		rsv_next[SV_MCAST]       = p_mcast;
		rsv_next[SV_BCAST]       = p_bcast;
		rsv_next[SV_DRIBBLE]     = (rx_dribble_bits != 3'd0);
		rsv_next[SV_CTRL]        = p_ctrl;
		rsv_next[SV_PAUSE]       = p_pause;
		rsv_next[SV_UNK_OP]      = p_unk;
		rsv_next[SV_VLAN]        = p_vlan;
		rsv_next[SV_FILT_LO+5:SV_FILT_LO] = rx_filter_match;
	end

	assign overflow_drop = rx_state == RSVC_RX_DATA && rx_eof && receive_enable_frame && rx_filter_pass &&
		(&pending_packet_count) && !dec_req;
	assign hdr_done = (rx_state == RSVC_RX_HDR) && (hdr_idx == 3'(HDR_BYTES - 1));

	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_state   <= RSVC_RX_IDLE;
			byte_cnt   <= 16'd0;
			rsv_reg    <= 48'h000000000000;
			hdr_idx    <= 3'd0;
			next_ptr   <= 16'd0;
			receive_enable_frame <= 1'b0;
		end else begin
			case (rx_state)
				RSVC_RX_IDLE: begin
					if (rx_sof) begin
						rx_state   <= RSVC_RX_DATA;
						byte_cnt   <= 16'd0;
						receive_enable_frame <= ctl_reg[CTL_RECEIVE_ENABLE];
					end
				end
				RSVC_RX_DATA: begin
					if (rx_valid)
						byte_cnt <= byte_cnt + 16'd1;
					if (rx_eof) begin
						if (receive_enable_frame && rx_filter_pass && !overflow_drop) begin
							rx_state <= RSVC_RX_HDR;
							rsv_reg  <= rsv_next;
							next_ptr <= wrap(raw_next, rx_buf_start);
							hdr_idx  <= 3'd0;
						end else begin
							rx_state <= RSVC_RX_IDLE;
						end
					end
				end
				RSVC_RX_HDR: begin
					hdr_idx <= hdr_idx + 3'd1;
					if (hdr_done)
						rx_state <= RSVC_RX_IDLE;
				end
				default: rx_state <= RSVC_RX_IDLE;
			endcase
		end
	end

	// Payload written behind the eight header bytes
	always_ff @(posedge mclk) begin
		if (rst) begin
			mem_wr_en   <= 1'b0;
			mem_wr_addr <= 16'd0;
			mem_wr_data <= 8'h00;
		end else begin
			mem_wr_en <= 1'b0;
			if (rx_state == RSVC_RX_DATA && rx_valid && receive_enable_frame) begin
				mem_wr_en   <= 1'b1;
				mem_wr_addr <= wrap(16'(rx_head_addr + 16'(HDR_BYTES) + byte_cnt), rx_buf_start);
				mem_wr_data <= rx_data;
			end else if (rx_state == RSVC_RX_HDR) begin
				mem_wr_en   <= 1'b1;
				mem_wr_addr <= wrap(16'(rx_head_addr + {13'd0, hdr_idx}), rx_buf_start);
				case (hdr_idx)
					3'd0: mem_wr_data <= next_ptr[7:0];
					3'd1: mem_wr_data <= next_ptr[15:8];
					3'd2: mem_wr_data <= rsv_reg[7:0];
					3'd3: mem_wr_data <= rsv_reg[15:8];
					3'd4: mem_wr_data <= rsv_reg[23:16];
					3'd5: mem_wr_data <= rsv_reg[31:24];
					3'd6: mem_wr_data <= rsv_reg[39:32];
					3'd7: mem_wr_data <= rsv_reg[47:40];
					default: mem_wr_data <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Pending packet count
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			pending_packet_count <= 8'd0;
			rx_commit            <= 1'b0;
			rx_next_head         <= 16'd0;
		end else begin
			rx_commit <= hdr_done;
			if (hdr_done)
				rx_next_head <= next_ptr;
			if (hdr_done && !(dec_req && pending_packet_count != 8'd0))
				pending_packet_count <= pending_packet_count + 8'd1;
			else if (!hdr_done && dec_req && pending_packet_count != 8'd0)
				pending_packet_count <= pending_packet_count - 8'd1;
		end
	end

	always_comb begin
		status_rdata               = 16'h0000;
		status_rdata[STA_FC_IDLE]  = flow_ctrl_idle;
		status_rdata[7:0]          = pending_packet_count;
	end
endmodule : rsvc_top

// ### rsvc_top_monitor.sv
`timescale 1ns/1ps
module rsvc_top_monitor import rsvc_pkg::*; #(
	parameter int PERIOD_CYC = PAUSE_PERIOD_CYC
) (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        ctl_wr,
	input wire logic [1:0]  ctl_be,
	input wire logic [15:0] ctl_wdata,
	input wire logic [15:0] ctl_rdata,
	input wire logic        rx_commit,
	input wire logic [7:0]  pending_packet_count,
	input wire logic        modexp_done,
	input wire logic        modexp_go,
	input wire logic        cipher_done,
	input wire logic        cipher_go,
	input wire logic [1:0]  cipher_op_select,
	input wire logic        cipher_op_reserved,
	input wire logic        digest_enable,
	input wire logic        digest_load_iv,
	input wire logic        digest_last_block,
	input wire logic        full_duplex_select,
	input wire logic        pause_req,
	input wire logic [15:0] pause_timer_out,
	input wire logic        pause_sent,
	input wire logic        backpressure
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence hi_write_s(int b);
		ctl_wr && ctl_be[1] && ctl_wdata[b] && !ctl_rdata[b];
	endsequence
	sequence fc_sent_s;
		full_duplex_select && pause_sent && ctl_rdata[6];
	endsequence
	sequence fc_cleared_s;
		##[1:2] ctl_rdata[7:6] == 2'b00;
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	modexp_start_a: assert property (hi_write_s(15) |=> ctl_rdata[15] && modexp_go ##1 !modexp_go)
		else $error("modexp start");
	modexp_hold_a: assert property (ctl_rdata[15] && !modexp_done |=> ctl_rdata[15])
		else $error("modexp hold");
	modexp_clear_a: assert property (modexp_done |=> !ctl_rdata[15])
		else $error("modexp clear");
	cipher_start_a: assert property (hi_write_s(11) |=> cipher_go && ctl_rdata[11])
		else $error("cipher start");
	cipher_end_a: assert property ($fell(ctl_rdata[11]) |-> $past(cipher_done))
		else $error("cipher end");
	cipher_decode_a: assert property (
		cipher_op_select == ctl_rdata[10:9] && cipher_op_reserved == (cipher_op_select == 2'b11))
		else $error("cipher decode");
	digest_ctrl_a: assert property (
		{digest_enable, digest_load_iv, digest_last_block} == ctl_rdata[14:12])
		else $error("digest ctrl");
	pending_count_decrement_count_a: assert property (
		hi_write_s(8) && pending_packet_count != 8'h00 && !rx_commit
		|=> pending_packet_count == $past(pending_packet_count) - 8'h01)
		else $error("count dec");
	commit_count_a: assert property (
		rx_commit |-> ##[0:1] pending_packet_count == $past(pending_packet_count, 2) + 8'h01)
		else $error("count inc");
	fc_self_clear_a: assert property (fc_sent_s |-> fc_cleared_s)
		else $error("fc self clear");
	pause_zero_a: assert property (
		pause_req && full_duplex_select && ctl_rdata[7:6] == 2'b11 |-> pause_timer_out == ZERO_TIMER)
		else $error("pause zero");
	backpressure_a: assert property (
		(!full_duplex_select && ctl_rdata[7:6] != 2'b00) [*3] |-> backpressure)
		else $error("backpressure");
endmodule : rsvc_top_monitor

bind rsvc_top rsvc_top_monitor #(.PERIOD_CYC(PERIOD_CYC)) rsvc_top_monitor_i (.mclk, .rst, .ctl_wr, .ctl_be,
	.ctl_wdata, .ctl_rdata, .rx_commit, .pending_packet_count, .modexp_done, .modexp_go, .cipher_done, .cipher_go,
	.cipher_op_select, .cipher_op_reserved, .digest_enable, .digest_load_iv, .digest_last_block,
	.full_duplex_select, .pause_req, .pause_timer_out, .pause_sent, .backpressure);

// ### rx_status_vector_and_control_reg_bench.sv
`timescale 1ns/1ps
module rx_status_vector_and_control_reg_bench import rsvc_pkg::*;;
	typedef struct packed {
		logic [1:0]  be;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [10:0] outs;
	} rsvc_row_t;
	localparam int PERIOD = 20;
	logic        mclk, rst, ctl_wr, rx_sof, rx_valid, rx_eof, rx_crc_ok, rx_symbol_err, rx_filter_pass;
	logic        rx_carrier_event, rx_drop_event, full_duplex_select, mem_wr_en, rx_commit, modexp_go;
	logic        cipher_go, cipher_op_reserved, digest_enable, digest_load_iv, digest_last_block, pause_req;
	logic        backpressure, flow_ctrl_idle, modexp_done, cipher_done, pause_sent;
	logic [1:0]  ctl_be, cipher_op_select;
	logic [2:0]  rx_dribble_bits;
	logic [4:0]  aux_ctrl;
	logic [5:0]  rx_filter_match;
	logic [7:0]  rx_data, mem_wr_data, pending_packet_count;
	logic [15:0] ctl_wdata, ctl_rdata, status_rdata, rx_buf_start, rx_head_addr, mem_wr_addr;
	logic [15:0] rx_next_head, pause_timer_value, pause_timer_out;
	logic [7:0]  mem [0:24575];
	int          mismatches = 0;
	int          checked = 0;
	int          commits = 0;
	int          r;
	logic [1:0]  ops [0:2] = '{2'b01, 2'b11, 2'b10};
	rsvc_row_t   rows [0:5] = '{{2'h3, 16'h7000, 16'h7000, 11'h0e0}, {2'h3, 16'h023e, 16'h023e, 11'h21f},
		{2'h3, 16'h0400, 16'h0400, 11'h400}, {2'h3, 16'h0600, 16'h0600, 11'h700},
		{2'h1, 16'hff21, 16'h0621, 11'h710}, {2'h2, 16'h40ff, 16'h4021, 11'h090}};

	rsvc_top #(.PERIOD_CYC(PERIOD)) rsvc_top_i (.mclk, .rst, .ctl_wr, .ctl_be, .ctl_wdata, .ctl_rdata, .status_rdata,
		.rx_sof, .rx_valid, .rx_data, .rx_eof, .rx_crc_ok, .rx_symbol_err, .rx_dribble_bits, .rx_filter_pass,
		.rx_filter_match, .rx_carrier_event, .rx_drop_event, .rx_buf_start, .rx_head_addr, .mem_wr_en, .mem_wr_addr,
		.mem_wr_data, .rx_commit, .rx_next_head, .pending_packet_count, .modexp_done, .modexp_go, .cipher_done,
		.cipher_go, .cipher_op_select, .cipher_op_reserved, .digest_enable, .digest_load_iv, .digest_last_block,
		.aux_ctrl, .full_duplex_select, .pause_timer_value, .pause_req, .pause_timer_out, .pause_sent, .backpressure,
		.flow_ctrl_idle);
	rsvc_far_model rsvc_far_model_i (.mclk, .rst, .modexp_go, .cipher_go, .pause_req, .modexp_done, .cipher_done,
		.pause_sent);

	// ----------------------------------------
	// Clock, buffer memory and commit count
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (mem_wr_en === 1'b1) mem[mem_wr_addr] <= mem_wr_data;
		if (rx_commit === 1'b1) commits <= commits + 1;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	function automatic logic cond(input int sel);
		case (sel)
			0: return ctl_rdata[15] === 1'b0;
			1: return ctl_rdata[11] === 1'b0;
			3: return pause_req === 1'b1;
			4: return backpressure === 1'b1;
			5: return flow_ctrl_idle === 1'b1;
			default: return ctl_rdata[7:6] === 2'b00;
		endcase
	endfunction : cond
	task automatic wait_cond(input int sel, input int lim);
		int n;
		n = 0;
		while (!cond(sel)) begin
			@(negedge mclk);
			n++;
			if (n > lim) begin
				mismatches++;
				$display("BAD %0t: wait %0d ran out", $time, sel);
				end_of_test();
			end
		end
	endtask : wait_cond
	task automatic wr(input logic [1:0] be, input logic [15:0] data, input int n);
		@(negedge mclk);
		ctl_wr = 1'b1;
		ctl_be = be;
		ctl_wdata = data;
		repeat (n) @(negedge mclk);
		ctl_wr = 1'b0;
	endtask : wr
	function automatic logic [7:0] fb(input int i, input logic [47:0] da, input logic [15:0] et);
		if (i < 6) return da[47 - 8 * i -: 8];
		if (i < 12) return 8'h02;
		if (i == 12) return et[15:8];
		if (i == 13) return et[7:0];
		if (i < 16) return (i == 15) ? 8'h01 : 8'h00;
		return i[7:0];
	endfunction : fb
	task automatic rx_frame(input logic [15:0] head, input logic [47:0] da, input logic [15:0] et, input logic crc,
		input logic [47:0] rx_status_vector, input int ncommit);
		int i;
		int c0;
		logic [63:0] hdr;
		c0 = commits;
		hdr = {rx_status_vector, head + 16'h0048};
		@(negedge mclk);
		rx_head_addr = head;
		rx_sof = 1'b1;
		for (i = 0; i < 64; i++) begin
			@(negedge mclk);
			rx_sof = 1'b0;
			rx_valid = 1'b1;
			rx_data = fb(i, da, et);
		end
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_eof = 1'b1;
		rx_crc_ok = crc;
		rx_symbol_err = !crc;
		@(negedge mclk);
		rx_eof = 1'b0;
		repeat (14) @(negedge mclk);
		check(commits - c0, ncommit);
		if (ncommit == 1) begin
			check(rx_next_head, hdr[15:0]);
			check({mem[head + 1], mem[head]}, hdr[15:0]);
			check({mem[head + 3], mem[head + 2]}, hdr[31:16]);
			check(mem[head + 4], hdr[39:32]);
			check(mem[head + 5], hdr[47:40]);
			check({mem[head + 7], mem[head + 6]}, hdr[63:48]);
			for (i = 0; i < 64; i++) check(mem[head + 8 + i], fb(i, da, et));
		end
	endtask : rx_frame
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst, ctl_wr, rx_sof, rx_valid, rx_eof, rx_crc_ok, rx_symbol_err} = 7'h40;
		{rx_carrier_event, rx_drop_event, full_duplex_select, ctl_be, ctl_wdata, rx_data} = 29'h0;
		rx_dribble_bits = 3'h3;
		rx_filter_pass = 1'b1;
		rx_filter_match = 6'h21;
		rx_buf_start = 16'h0100;
		rx_head_addr = 16'h0100;
		pause_timer_value = 16'h1234;
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		check(ctl_rdata, 16'h0000);
		check(status_rdata, 16'h4000);
		for (r = 0; r < 6; r++) begin
			wr(rows[r].be, rows[r].wdata, 1);
			check(ctl_rdata, rows[r].rdata);
			check({cipher_op_select, cipher_op_reserved, digest_enable, digest_load_iv, digest_last_block,
				aux_ctrl}, rows[r].outs);
		end
		wr(2'h3, 16'h0000, 1);
		wr(2'h2, 16'h8000, 1);
		check({modexp_go, ctl_rdata[15]}, 2'b11);
		wr(2'h2, 16'h0000, 1);
		check(ctl_rdata[15], 1'b1);
		wait_cond(0, 40);
		wr(2'h2, 16'h0c00, 1);
		check({cipher_go, ctl_rdata[11], cipher_op_select}, 4'he);
		wait_cond(1, 40);
		check(cipher_op_select, 2'b10);
		wr(2'h3, 16'h0001, 1);
		@(negedge mclk);
		{rx_carrier_event, rx_drop_event} = 2'b11;
		@(negedge mclk);
		{rx_carrier_event, rx_drop_event} = 2'b00;
		rx_frame(16'h0100, 48'hffffffffffff, 16'h0800, 1'b1, 48'h001086c50040, 1);
		rx_frame(16'h0148, 48'h0180c2000001, 16'h8808, 1'b0, 48'h00109d500040, 1);
		wr(2'h1, 16'h0000, 1);
		rx_frame(16'h0190, 48'hffffffffffff, 16'h0800, 1'b1, 48'h0, 0);
		check(status_rdata, 16'h4002);
		wr(2'h2, 16'h0100, 2);
		check({ctl_rdata[8], pending_packet_count}, 9'h000);
		wr(2'h2, 16'h0100, 1);
		check(pending_packet_count, 8'h00);
		wait_cond(5, 10);
		wr(2'h1, 16'h0040, 1);
		wait_cond(4, 10);
		check(backpressure, 1'b1);
		rst = 1'b1;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		check({backpressure, ctl_rdata}, 17'h0);
		full_duplex_select = 1'b1;
		for (r = 0; r < 3; r++) begin
			wait_cond(5, 60);
			wr(2'h1, {8'h00, ops[r], 6'h00}, 1);
			wait_cond(3, 10);
			check(pause_timer_out, (ops[r] == 2'b11) ? 16'h0000 : 16'h1234);
			if (ops[r] != 2'b10) begin
				wait_cond(6, 20);
			end else begin
				@(negedge mclk);
				wait_cond(3, 2 * PERIOD + 10);
				check(pause_req, 1'b1);
			end
		end
		end_of_test();
	end
endmodule : rx_status_vector_and_control_reg_bench
